// >>> bssp_core.sv
// Buck switch sequencer with power-good qualification and AHB-Lite registers
`timescale 1ns/1ps
`include "bssp_defines.svh"

module bssp_core #(
   parameter logic [7:0] MIN_ON_CYC = 8'(`BSSP_MIN_ON_RST),
   parameter logic [7:0] MIN_OFF_CYC = 8'(`BSSP_MIN_OFF_RST)
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire bssp_pkg::bssp_ahb_req_t ahb_req,
   output bssp_pkg::bssp_ahb_rsp_t ahb_rsp,
   input wire logic sync_in,
   input wire logic shutdown_low_input,
   input wire logic undervoltage_lockout,
   input wire logic sense_resistor_select,
   input wire logic current_at_threshold,
   input wire logic feedback_in_window,
   output bssp_pkg::bssp_pwr_t pwr,
   output logic inverted_clock_output,
   output logic inverted_clock_oe_n,
   output logic power_ok_flag,
   output logic power_ok_flag_oe_n
);

   // ==================================================
   // State and working signals
   bssp_pkg::bssp_state_t s_q;
   bssp_pkg::bssp_state_t s_d;
   logic en;
   logic fall;
   logic addr_ok;
   logic [11:0] per;
   logic [31:0] rd;

   // ==================================================
   // Next state
   always_comb begin
      s_d = s_q;
      rd = 32'h0000_0000;
      en = shutdown_low_input & ~undervoltage_lockout;

      // Internal oscillator rate from the sync level
      per = sync_in ? 12'(`BSSP_PER_HI) : 12'(`BSSP_PER_LO);
      s_d.div = (s_q.div >= per - 12'h001) ? 12'h000 : s_q.div + 12'h001;

      // A toggling sync input takes over as reference
      s_d.sync_prev = sync_in;
      if (sync_in != s_q.sync_prev) begin
         s_d.loss = 12'h000;
         s_d.ext = 1'b1;
      end else if (s_q.loss >= 12'(`BSSP_SYNC_LOSS) - 12'h001) begin
         s_d.ext = 1'b0;
      end else begin
         s_d.loss = s_q.loss + 12'h001;
      end
      s_d.ref_clk = s_q.ext ? sync_in : (s_q.div < (per >> 1));
      fall = s_q.ref_clk & ~s_d.ref_clk;

      // Switch sequencer
      if (!en) begin
         s_d.st = bssp_pkg::BSSP_IDLE;
         s_d.tmr = 8'h00;
      end else if (fall) begin
         s_d.st = bssp_pkg::BSSP_MINOFF;
         s_d.tmr = s_q.min_off;
      end else begin
         case (s_q.st)
            bssp_pkg::BSSP_IDLE: begin
               s_d.st = bssp_pkg::BSSP_LSON;
            end
            bssp_pkg::BSSP_MINOFF: begin
               if (s_q.tmr <= 8'h01) begin
                  s_d.st = bssp_pkg::BSSP_MINON;
                  s_d.tmr = s_q.min_on;
               end else begin
                  s_d.tmr = s_q.tmr - 8'h01;
               end
            end
            bssp_pkg::BSSP_MINON: begin
               if (s_q.tmr <= 8'h01) begin
                  s_d.st = bssp_pkg::BSSP_HSON;
               end else begin
                  s_d.tmr = s_q.tmr - 8'h01;
               end
            end
            bssp_pkg::BSSP_HSON: begin
               if (current_at_threshold) begin
                  s_d.st = bssp_pkg::BSSP_LSON;
               end
            end
            bssp_pkg::BSSP_LSON: begin
               s_d.st = bssp_pkg::BSSP_LSON;
            end
            default: begin
               s_d.st = bssp_pkg::BSSP_IDLE;
            end
         endcase
      end

      // Switch controls follow the next state; soft-start discharge and resistor select follow their inputs
      s_d.pwr.hs_on = (s_d.st == bssp_pkg::BSSP_MINON) || (s_d.st == bssp_pkg::BSSP_HSON);
      s_d.pwr.ls_on = (s_d.st == bssp_pkg::BSSP_MINOFF) || (s_d.st == bssp_pkg::BSSP_LSON);
      s_d.pwr.out_hiz = (s_d.st == bssp_pkg::BSSP_IDLE);
      s_d.pwr.ramp_reset = s_d.pwr.ls_on;
      s_d.pwr.ss_discharge = ~shutdown_low_input;
      s_d.pwr.use_ext_resistor = sense_resistor_select;

      // Power-ok qualification; agreement between flag and window clears the count
      if (!en) begin
         s_d.pg_cnt = 7'h00;
         s_d.pok = 1'b0;
      end else if (s_q.pok == feedback_in_window) begin
         s_d.pg_cnt = 7'h00;
      end else if (fall) begin
         if (s_q.pg_cnt >= 7'(`BSSP_PG_COUNT) - 7'h01) begin
            s_d.pg_cnt = 7'h00;
            s_d.pok = ~s_q.pok;
         end else begin
            s_d.pg_cnt = s_q.pg_cnt + 7'h01;
         end
      end

      // Bus write lands in its data phase
      if (s_q.wr_pend && (s_q.wr_addr == `BSSP_CTRL_OFS)) begin
         s_d.min_on = ahb_req.hwdata[`BSSP_CTRL_ON_LSB +: 8];
         s_d.min_off = ahb_req.hwdata[`BSSP_CTRL_OFF_LSB +: 8];
      end

      // Bus address phase
      addr_ok = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready
         & (ahb_req.hsize == 3'b010);
      s_d.wr_pend = addr_ok & ahb_req.hwrite;
      s_d.wr_addr = ahb_req.haddr;
      if (ahb_req.haddr == `BSSP_CTRL_OFS) begin
         rd[`BSSP_CTRL_ON_LSB +: 8] = s_d.min_on;
         rd[`BSSP_CTRL_OFF_LSB +: 8] = s_d.min_off;
      end else if (ahb_req.haddr == `BSSP_STAT_OFS) begin
         rd[`BSSP_STAT_EXT] = s_q.ext;
         rd[`BSSP_STAT_POK] = s_q.pok;
         rd[`BSSP_STAT_EN] = en;
         rd[`BSSP_STAT_WIN] = feedback_in_window;
         rd[`BSSP_STAT_ST_LSB +: 3] = s_q.st;
         rd[`BSSP_STAT_PGC_LSB +: 7] = s_q.pg_cnt;
      end
      if (addr_ok && !ahb_req.hwrite) begin
         s_d.rdata = rd;
      end
   end

   // ==================================================
   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.st <= bssp_pkg::BSSP_IDLE;
         s_q.min_on <= MIN_ON_CYC;
         s_q.min_off <= MIN_OFF_CYC;
         s_q.sync_prev <= 1'b1;
         s_q.pwr.out_hiz <= 1'b1;
         s_q.pwr.ss_discharge <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==================================================
   // Outputs
   assign ahb_rsp = '{hrdata: s_q.rdata, hreadyout: 1'b1, hresp: 1'b0};
   assign pwr = s_q.pwr;
   // Pin pulled low while the reference is high
   assign inverted_clock_output = 1'b0;
   assign inverted_clock_oe_n = ~s_q.ref_clk;
   // Pin released when power is good
   assign power_ok_flag = 1'b0;
   assign power_ok_flag_oe_n = s_q.pok;

   // ==================================================
   // Assertions
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_fall_restart;
      en && fall |=> s_q.st == bssp_pkg::BSSP_MINOFF && pwr.ls_on && !pwr.hs_on;
   endproperty
   a_fall_restart: assert property (p_fall_restart)
      else $error("falling edge did not start minimum off-time");

   property p_min_on;
      s_q.st == bssp_pkg::BSSP_MINON && s_q.tmr > 8'h01 && en && !fall
         |=> pwr.hs_on && s_q.st == bssp_pkg::BSSP_MINON;
   endproperty
   a_min_on: assert property (p_min_on)
      else $error("high side left before minimum on-time");

   property p_thr_off;
      s_q.st == bssp_pkg::BSSP_HSON && current_at_threshold && en && !fall
         |=> pwr.ls_on && !pwr.hs_on;
   endproperty
   a_thr_off: assert property (p_thr_off)
      else $error("threshold did not hand over to low side");

   property p_ls_hold;
      s_q.st == bssp_pkg::BSSP_LSON && en && !fall |=> pwr.ls_on;
   endproperty
   a_ls_hold: assert property (p_ls_hold)
      else $error("low side released before falling edge");

   property p_no_dcm;
      !pwr.out_hiz |-> pwr.hs_on != pwr.ls_on;
   endproperty
   a_no_dcm: assert property (p_no_dcm)
      else $error("switches not complementary while switching");

   property p_ramp;
      pwr.ls_on |-> pwr.ramp_reset;
   endproperty
   a_ramp: assert property (p_ramp)
      else $error("ramp not held in reset with low side on");

   property p_shutdown;
      !shutdown_low_input |=> pwr.out_hiz && !pwr.hs_on && !pwr.ls_on && pwr.ss_discharge;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("shutdown did not tri-state output");

   property p_ss_release;
      shutdown_low_input |=> !pwr.ss_discharge;
   endproperty
   a_ss_release: assert property (p_ss_release)
      else $error("soft-start discharge held after release");

   property p_lockout;
      undervoltage_lockout |=> pwr.out_hiz;
   endproperty
   a_lockout: assert property (p_lockout)
      else $error("switching during lockout");

   property p_pg_assert;
      en && !s_q.pok && feedback_in_window && fall && s_q.pg_cnt == 7'd63 |=> s_q.pok;
   endproperty
   a_pg_assert: assert property (p_pg_assert)
      else $error("power-ok not asserted at count 64");

   property p_pg_early;
      en && !s_q.pok && s_q.pg_cnt < 7'd63 |=> !s_q.pok;
   endproperty
   a_pg_early: assert property (p_pg_early)
      else $error("power-ok asserted early");

   property p_pg_abort;
      en && !s_q.pok && !feedback_in_window |=> s_q.pg_cnt == 7'h00 && !s_q.pok;
   endproperty
   a_pg_abort: assert property (p_pg_abort)
      else $error("assertion count not cleared on window exit");

   property p_pg_deassert;
      en && s_q.pok && !feedback_in_window && fall && s_q.pg_cnt == 7'd63 |=> !s_q.pok;
   endproperty
   a_pg_deassert: assert property (p_pg_deassert)
      else $error("power-ok not released at count 64");

   property p_pg_keep;
      en && s_q.pok && feedback_in_window |=> s_q.pg_cnt == 7'h00 && s_q.pok;
   endproperty
   a_pg_keep: assert property (p_pg_keep)
      else $error("deassertion count not cleared on window return");

   property p_pg_off;
      !en |=> !s_q.pok && s_q.pg_cnt == 7'h00 && !power_ok_flag_oe_n;
   endproperty
   a_pg_off: assert property (p_pg_off)
      else $error("power-ok active while disabled");

   property p_inv_clk;
      s_q.ext && $changed(s_q.ref_clk) |-> $changed(inverted_clock_oe_n);
   endproperty
   a_inv_clk: assert property (p_inv_clk)
      else $error("inverted clock did not follow reference");

   property p_minoff_hold;
      s_q.st == bssp_pkg::BSSP_MINOFF && s_q.tmr > 8'h01 && en && !fall
         |=> pwr.ls_on && s_q.st == bssp_pkg::BSSP_MINOFF;
   endproperty
   a_minoff_hold: assert property (p_minoff_hold)
      else $error("low side left before minimum off-time");

   property p_minoff_to_on;
      s_q.st == bssp_pkg::BSSP_MINOFF && s_q.tmr <= 8'h01 && en && !fall
         |=> s_q.st == bssp_pkg::BSSP_MINON && pwr.hs_on && s_q.tmr == $past(s_q.min_on);
   endproperty
   a_minoff_to_on: assert property (p_minoff_to_on)
      else $error("minimum on-time did not follow minimum off-time");

   property p_hs_wait;
      s_q.st == bssp_pkg::BSSP_HSON && !current_at_threshold && en && !fall
         |=> pwr.hs_on && s_q.st == bssp_pkg::BSSP_HSON;
   endproperty
   a_hs_wait: assert property (p_hs_wait)
      else $error("high side left before threshold");

   property p_ext_lock;
      sync_in != s_q.sync_prev |=> s_q.ext;
   endproperty
   a_ext_lock: assert property (p_ext_lock)
      else $error("toggling sync did not take over the reference");

   property p_ext_ref;
      s_q.ext |=> s_q.ref_clk == $past(sync_in);
   endproperty
   a_ext_ref: assert property (p_ext_ref)
      else $error("reference does not follow the sync input");

   property p_sense_resistor_select;
      1'b1 |=> pwr.use_ext_resistor == $past(sense_resistor_select);
   endproperty
   a_sense_resistor_select: assert property (p_sense_resistor_select)
      else $error("threshold resistor select not applied");

   property p_pg_step;
      en && s_q.pok != feedback_in_window && fall && s_q.pg_cnt < 7'd63
         |=> s_q.pg_cnt == $past(s_q.pg_cnt) + 7'h01 && s_q.pok == $past(s_q.pok);
   endproperty
   a_pg_step: assert property (p_pg_step)
      else $error("power-ok count did not advance on a reference edge");

   property p_pg_wait;
      en && s_q.pok != feedback_in_window && !fall
         |=> $stable(s_q.pg_cnt) && $stable(s_q.pok);
   endproperty
   a_pg_wait: assert property (p_pg_wait)
      else $error("power-ok count moved between reference edges");

   property p_ctrl_write;
      s_q.wr_pend && s_q.wr_addr == `BSSP_CTRL_OFS
         |=> s_q.min_on == $past(ahb_req.hwdata[`BSSP_CTRL_ON_LSB +: 8])
            && s_q.min_off == $past(ahb_req.hwdata[`BSSP_CTRL_OFF_LSB +: 8]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control write did not land");

   property p_ctrl_read;
      addr_ok && !ahb_req.hwrite && ahb_req.haddr == `BSSP_CTRL_OFS
         |=> ahb_rsp.hrdata[`BSSP_CTRL_ON_LSB +: 8] == s_q.min_on
            && ahb_rsp.hrdata[`BSSP_CTRL_OFF_LSB +: 8] == s_q.min_off;
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control read returned stale counts");

   c_cycle: cover property (fall ##[1:300] s_q.st == bssp_pkg::BSSP_HSON
      ##[1:300] s_q.st == bssp_pkg::BSSP_LSON);
   c_pok_rise: cover property (!s_q.pok ##1 s_q.pok);
   c_pok_fall: cover property (s_q.pok ##1 !s_q.pok);
   c_ext_sync: cover property (!s_q.ext ##1 s_q.ext);
   c_ext_drop: cover property (s_q.ext ##1 !s_q.ext);

endmodule // bssp_core

// >>> bssp_defines.svh
// Offsets, field positions, reset values and timing counts of the buck sequencer
`ifndef BSSP_DEFINES_SVH
`define BSSP_DEFINES_SVH

// ==================================================
// Register map
`define BSSP_CTRL_OFS 32'h0000_0000
`define BSSP_STAT_OFS 32'h0000_0004

// ==================================================
// Control fields
`define BSSP_CTRL_ON_LSB 0
`define BSSP_CTRL_OFF_LSB 8

// ==================================================
// Status fields
`define BSSP_STAT_EXT 0
`define BSSP_STAT_POK 1
`define BSSP_STAT_EN 2
`define BSSP_STAT_WIN 3
`define BSSP_STAT_ST_LSB 4
`define BSSP_STAT_PGC_LSB 8

// ==================================================
// Reset values of the minimum on and off counts
`define BSSP_MIN_ON_RST 8
`define BSSP_MIN_OFF_RST 8

// ==================================================
// Timing
`define BSSP_CLK_HZ 125000000
`define BSSP_OSC_HI_HZ 1000000
`define BSSP_OSC_LO_HZ 500000
`define BSSP_SYNC_MIN_HZ 100000
`define BSSP_PER_HI (`BSSP_CLK_HZ / `BSSP_OSC_HI_HZ)
`define BSSP_PER_LO (`BSSP_CLK_HZ / `BSSP_OSC_LO_HZ)
`define BSSP_SYNC_LOSS (2 * (`BSSP_CLK_HZ / `BSSP_SYNC_MIN_HZ))
`define BSSP_PG_COUNT 64

`endif

// >>> bssp_pkg.sv
// Types shared by the buck sequencer
package bssp_pkg;

   typedef enum logic [2:0] {
      BSSP_IDLE = 3'b000,
      BSSP_MINOFF = 3'b001,
      BSSP_MINON = 3'b011,
      BSSP_HSON = 3'b010,
      BSSP_LSON = 3'b110
   } bssp_st_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } bssp_ahb_req_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } bssp_ahb_rsp_t;

   typedef struct packed {
      logic hs_on;
      logic ls_on;
      logic out_hiz;
      logic ramp_reset;
      logic ss_discharge;
      logic use_ext_resistor;
   } bssp_pwr_t;

   typedef struct packed {
      bssp_st_t st;
      logic [7:0] tmr;
      logic [11:0] div;
      logic ref_clk;
      logic sync_prev;
      logic [11:0] loss;
      logic ext;
      logic [6:0] pg_cnt;
      logic pok;
      logic [7:0] min_on;
      logic [7:0] min_off;
      logic wr_pend;
      logic [31:0] wr_addr;
      logic [31:0] rdata;
      bssp_pwr_t pwr;
   } bssp_state_t;

endpackage

// >>> bssp_stage_model.sv
// Power stage, current comparator and sync source model
`timescale 1ns/1ps
module bssp_stage_model (
   input wire logic hclk,
   input wire bssp_pkg::bssp_pwr_t pwr,
   input wire logic [1:0] cmp_mode,
   input wire logic [9:0] sync_half,
   input wire logic sync_lvl,
   output logic current_at_threshold,
   output logic sync_in
);
   logic [7:0] hs_run;
   logic [9:0] sync_cnt;
   initial begin
      hs_run = 8'h00;
      sync_cnt = 10'h000;
      current_at_threshold = 1'b0;
      sync_in = 1'b1;
   end
   // ========
   // Comparator: 0 never trips, 1 stuck high, 2 trips after a fixed ramp
   always @(posedge hclk) begin
      hs_run <= pwr.hs_on ? hs_run + 8'h01 : 8'h00;
      current_at_threshold <= (cmp_mode == 2'h1) || (cmp_mode == 2'h2 && hs_run >= 8'h14);
   end
   // ========
   // Sync pin: static level, or a square wave toggling every sync_half cycles
   always @(posedge hclk) begin
      if (sync_half == 10'h000) begin
         sync_cnt <= 10'h000;
         sync_in <= sync_lvl;
      end else if (sync_cnt + 10'h001 >= sync_half) begin
         sync_cnt <= 10'h000;
         sync_in <= ~sync_in;
      end else begin
         sync_cnt <= sync_cnt + 10'h001;
      end
   end
endmodule // bssp_stage_model

// >>> buck_switch_sequencer_power_ok_flag_test.sv
// Self-checking bench of the buck sequencer
`timescale 1ns/1ps
module buck_switch_sequencer_power_ok_flag_test;
   logic hclk;
   logic hresetn = 1'b0;
   bssp_pkg::bssp_ahb_req_t req;
   bssp_pkg::bssp_ahb_rsp_t rsp;
   bssp_pkg::bssp_pwr_t pwr;
   logic sync_in, cat, clk_o, clk_oe_n, pok, pok_oe_n;
   logic shutdown_low_input = 1'b0;
   logic undervoltage_lockout = 1'b0;
   logic sel = 1'b0;
   logic win = 1'b0;
   logic [1:0] cmp_mode = 2'h2;
   logic [9:0] sync_half = 10'h000;
   logic sync_lvl = 1'b1;
   logic mon_on = 1'b0;
   logic hs_prev = 1'b0;
   logic oe_prev = 1'b1;
   logic [31:0] rd;
   int mismatches = 0;
   int compares = 0;
   int rises = 0;
   int ref_rises = 0;
   int hs_len = 0;
   int ls_len = 0;
   int exp_on = 4;
   int exp_off = 3;

   bssp_core uut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp),
      .sync_in(sync_in), .shutdown_low_input(shutdown_low_input),
      .undervoltage_lockout(undervoltage_lockout), .sense_resistor_select(sel),
      .current_at_threshold(cat), .feedback_in_window(win), .pwr(pwr),
      .inverted_clock_output(clk_o), .inverted_clock_oe_n(clk_oe_n),
      .power_ok_flag(pok), .power_ok_flag_oe_n(pok_oe_n));
   bssp_stage_model model (.hclk(hclk), .pwr(pwr), .cmp_mode(cmp_mode),
      .sync_half(sync_half), .sync_lvl(sync_lvl), .current_at_threshold(cat),
      .sync_in(sync_in));

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // ========
   // Shared tasks
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wait_rdy(output logic [31:0] d);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (rsp.hreadyout !== 1'b1 && n < 50);
      d = rsp.hrdata;
      if (n >= 50) begin
         mismatches++;
         tally_and_finish;
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
      req.hsel <= 1'b1;
      req.haddr <= a;
      req.htrans <= 2'h2;
      req.hwrite <= wr;
      wait_rdy(d);
      req.hsel <= 1'b0;
      req.htrans <= 2'h0;
      req.hwdata <= wd;
      wait_rdy(d);
   endtask
   task automatic wait_rises(input int n);
      int k;
      int t;
      t = rises + n;
      k = 0;
      while (rises < t && k < 400 * n) begin
         @(posedge hclk);
         k++;
      end
      if (k >= 400 * n) begin
         mismatches++;
         tally_and_finish;
      end
   endtask
   task automatic rate(input int cyc, input int lo, input int hi);
      int r0;
      int f0;
      int d;
      r0 = rises;
      f0 = ref_rises;
      repeat (cyc) @(posedge hclk);
      d = (ref_rises - f0) - (rises - r0);
      check("switch_cycles", 32'h1, 32'((rises - r0) >= lo && (rises - r0) <= hi));
      check("clock_out_edges", 32'h1, 32'(d >= -1 && d <= 1));
   endtask
   task automatic sync_mode(input logic [9:0] half, input int cyc, input int lo, input int hi);
      sync_half <= half;
      sync_lvl <= 1'b0;
      repeat (3000) @(posedge hclk);
      rate(cyc, lo, hi);
   endtask
   task automatic pg(input logic w, input int n, input logic exp);
      win <= w;
      wait_rises(n);
      check("power_ok", 32'(exp), 32'(pok_oe_n));
   endtask
   // ========
   // Switch monitor: overlap, run lengths, cycle starts
   always @(posedge hclk) begin
      if (mon_on === 1'b1) begin
         check("one_switch_on", 32'h1, 32'(pwr.hs_on ^ pwr.ls_on));
         check("ramp_reset", 32'(pwr.ls_on), 32'(pwr.ramp_reset));
         if (pwr.hs_on === 1'b1) hs_len++;
         else if (hs_len > 0) begin
            check("on_time", 32'h1, 32'(hs_len >= exp_on));
            hs_len = 0;
         end
         if (pwr.ls_on === 1'b1) ls_len++;
         else if (ls_len > 0) begin
            check("off_time", 32'h1, 32'(ls_len >= exp_off));
            ls_len = 0;
         end
         if (pwr.hs_on === 1'b1 && hs_prev !== 1'b1) rises++;
      end else begin
         hs_len = 0;
         ls_len = 0;
      end
      if (clk_oe_n === 1'b0 && oe_prev === 1'b1) ref_rises++;
      hs_prev = pwr.hs_on;
      oe_prev = clk_oe_n;
   end
   // ========
   // Main sequence
   initial begin
      req = '0;
      req.hsize = 3'h2;
      req.hready = 1'b1;
      repeat (10) @(posedge hclk);
      check("reset_outputs", 32'h26, 32'({pwr.out_hiz, pwr.hs_on, pwr.ls_on,
         pwr.ss_discharge, clk_oe_n, pok_oe_n}));
      check("od_data", 32'h0, 32'({clk_o, pok, rsp.hresp}));
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, 32'h0, 32'h0, rd);
      check("ctrl_reset", 32'h0000_0808, rd);
      bus(1'b1, 32'h0, 32'h0000_0304, rd);
      bus(1'b0, 32'h0, 32'h0, rd);
      check("ctrl", 32'h0000_0304, rd);
      req.hsize <= 3'h0;
      bus(1'b1, 32'h0, 32'h0000_0909, rd);
      req.hsize <= 3'h2;
      bus(1'b0, 32'h0, 32'h0, rd);
      check("ctrl_narrow", 32'h0000_0304, rd);
      bus(1'b0, 32'h0000_0010, 32'h0, rd);
      check("unmapped", 32'h0, rd);
      shutdown_low_input <= 1'b1;
      undervoltage_lockout <= 1'b1;
      repeat (5) @(posedge hclk);
      check("locked_out", 32'h2, 32'({pwr.out_hiz, pwr.ss_discharge}));
      undervoltage_lockout <= 1'b0;
      repeat (5) @(posedge hclk);
      check("enabled", 32'h0, 32'({pwr.out_hiz, pwr.ss_discharge}));
      mon_on <= 1'b1;
      bus(1'b0, 32'h4, 32'h0, rd);
      check("status", 32'h4, rd & 32'h5);
      sel <= 1'b1;
      repeat (3) @(posedge hclk);
      check("ext_resistor", 32'h1, 32'(pwr.use_ext_resistor));
      sel <= 1'b0;
      repeat (3000) @(posedge hclk);
      check("int_resistor", 32'h0, 32'(pwr.use_ext_resistor));
      for (int m = 0; m < 3; m++) begin
         cmp_mode <= 2'(m);
         repeat (300) @(posedge hclk);
         rate(1250, 9, 11);
      end
      pg(1'b1, 40, 1'b0);
      pg(1'b0, 2, 1'b0);
      pg(1'b1, 63, 1'b0);
      pg(1'b1, 2, 1'b1);
      pg(1'b0, 40, 1'b1);
      pg(1'b1, 2, 1'b1);
      pg(1'b0, 63, 1'b1);
      pg(1'b0, 2, 1'b0);
      pg(1'b1, 66, 1'b1);
      bus(1'b0, 32'h4, 32'h0, rd);
      check("window_status", 32'h0000_000A, rd & 32'h0000_000A);
      mon_on <= 1'b0;
      shutdown_low_input <= 1'b0;
      repeat (3) @(posedge hclk);
      check("shutdown", 32'h18, 32'({pwr.out_hiz, pwr.ss_discharge, pwr.hs_on,
         pwr.ls_on, pok_oe_n}));
      shutdown_low_input <= 1'b1;
      repeat (3) @(posedge hclk);
      check("restart", 32'h0, 32'({pwr.out_hiz, pok_oe_n}));
      mon_on <= 1'b1;
      sync_mode(10'h000, 2500, 9, 11);
      sync_mode(10'h00D, 1300, 48, 52);
      sync_mode(10'h271, 5000, 3, 5);
      bus(1'b0, 32'h4, 32'h0, rd);
      check("ext_mode", 32'h1, rd & 32'h1);
      tally_and_finish;
   end
endmodule // buck_switch_sequencer_power_ok_flag_test
